// *** hdl/dcpo_pkg.sv ***
package dcpo_pkg;
	localparam int          NCH           = 2;
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          TB_FINE_NS    = 100000;
	localparam int          TB_COARSE_NS  = 1000000;
	localparam int          TB_MICRO_NS   = 1000;
	localparam int          TB_FINE_CYC   = (TB_FINE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          TB_COARSE_CYC = (TB_COARSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          TB_MICRO_CYC  = (TB_MICRO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          ADDR_W        = 12;
	localparam logic [11:0] A_CTRL        = 12'h000;
	localparam logic [11:0] A_DOUT        = 12'h004;
	localparam logic [11:0] A_FREQ        = 12'h008;
	localparam logic [11:0] A_STATUS      = 12'h00c;
	localparam logic [11:0] A_CH_BASE     = 12'h010;
	localparam logic [11:0] A_CH_END      = 12'h030;
	localparam int          CH_SHIFT      = 4;
	localparam logic [3:0]  OFF_PERIOD    = 4'h0;
	localparam logic [3:0]  OFF_DUTY      = 4'h4;
	localparam logic [3:0]  OFF_MINP      = 4'h8;
	localparam logic [15:0] PERIOD_MIN    = 16'h0002;
	localparam logic [15:0] PERIOD_MAX    = 16'hea60;
	localparam logic [15:0] DUTY_MIN      = 16'h0001;
	localparam logic [15:0] DUTY_MAX      = 16'h03e8;
	localparam logic [15:0] MINP_STD_MIN  = 16'h0001;
	localparam logic [15:0] MINP_HF_MIN   = 16'h0002;
	localparam logic [15:0] MINP_MAX      = 16'hea60;
	localparam logic [15:0] FREQ_MIN      = 16'h09c4;
	localparam logic [15:0] FREQ_MAX      = 16'hc350;
	localparam logic [25:0] PERMIL        = 26'h00003e8;
	localparam logic [19:0] US_PER_S      = 20'hf4240;
	localparam logic [15:0] PERIOD_RST    = 16'h0064;
	localparam logic [9:0]  DUTY_RST      = 10'h1f4;
	localparam logic [15:0] MINP_RST      = 16'h0001;
	localparam logic [15:0] FREQ_RST      = 16'h09c4;

	typedef enum logic [1:0] {DCPO_TB_FINE, DCPO_TB_COARSE, DCPO_TB_MICRO} dcpo_tb_t;

	// bit 0..1 enables, bit 2 mode, bit 3..4 per-channel 1 ms time base
	typedef struct packed {
		logic [1:0] tb_coarse;
		logic       high_frequency_modulation_mode;
		logic [1:0] en;
	} dcpo_ctrl_t;
	localparam int CTRL_W = $bits(dcpo_ctrl_t);

	typedef struct packed {
		logic [15:0] period;
		logic [9:0]  duty;
		logic [15:0] minp;
	} dcpo_timing_t;

	typedef struct packed {
		logic [15:0] period;
		logic [15:0] pulse;
		logic [15:0] minp;
	} dcpo_sched_t;

	function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
			input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	function automatic logic [15:0] pulse_ticks(input logic [15:0] p, input logic [9:0] d);
		logic [25:0] prod;
		logic [25:0] quo;
		prod = {10'h000, p} * {16'h0000, d};
		quo = prod / PERMIL;
		pulse_ticks = quo[15:0];
	endfunction

	function automatic logic [15:0] hf_period_ticks(input logic [15:0] f);
		logic [19:0] quo;
		quo = US_PER_S / {4'h0, f};
		hf_period_ticks = quo[15:0];
	endfunction
endpackage

// *** hdl/dcpo_tick_gen.sv ***
`timescale 1ns/1ns
module dcpo_tick_gen #(
	parameter int FINE_CYC   = dcpo_pkg::TB_FINE_CYC,
	parameter int COARSE_CYC = dcpo_pkg::TB_COARSE_CYC,
	parameter int MICRO_CYC  = dcpo_pkg::TB_MICRO_CYC
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             clr,
	input  wire dcpo_pkg::dcpo_tb_t sel,
	output logic                  tick
);
	logic [15:0] cnt_r;
	logic [15:0] lim;

	always_comb begin
		case (sel)
			dcpo_pkg::DCPO_TB_COARSE: lim = 16'(COARSE_CYC - 1);
			dcpo_pkg::DCPO_TB_MICRO:  lim = 16'(MICRO_CYC - 1);
			default:                  lim = 16'(FINE_CYC - 1);
		endcase
	end

	// restart on clear so the first period after enable starts with a full tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 16'h0000;
			tick  <= 1'b0;
		end else if (clr) begin
			cnt_r <= 16'h0000;
			tick  <= 1'b0;
		end else if (cnt_r >= lim) begin
			cnt_r <= 16'h0000;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			tick  <= 1'b0;
		end
	end

	a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		tick |=> !tick [*8]) else $error("ticks closer than the prescaler allows");
endmodule // dcpo_tick_gen

// *** hdl/dcpo_channel.sv ***
`timescale 1ns/1ns
module dcpo_channel (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  en,
	input  wire logic                  tick,
	input  wire dcpo_pkg::dcpo_sched_t sched,
	output logic                       level,
	output logic                       suppressed
);
	logic [15:0]           cnt_r;
	dcpo_pkg::dcpo_sched_t act_r;
	logic                  wrap;

	assign wrap = ({1'b0, cnt_r} + 17'h00001) >= {1'b0, act_r.period};

	// timing is sampled every cycle while disabled and at a period boundary, never mid-period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 16'h0000;
			act_r <= '0;
		end else if (!en) begin
			cnt_r <= 16'h0000;
			act_r <= sched;
		end else if (tick) begin
			if (wrap) begin
				cnt_r <= 16'h0000;
				act_r <= sched;
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end

	assign suppressed = act_r.pulse <= act_r.minp;
	assign level = en && !suppressed && (cnt_r < act_r.pulse);

	a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(en && !(tick && wrap)) ##1 en |-> $stable(act_r))
		else $error("timing changed inside a period");
	a_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
		$past(en) && en |-> cnt_r < act_r.period)
		else $error("period counter ran past the period");
	a_break_low: assert property (@(posedge pclk) disable iff (!presetn)
		en && (cnt_r >= act_r.pulse) |-> !level)
		else $error("output high during break");
endmodule // dcpo_channel

// *** hdl/dcpo_top.sv ***
`timescale 1ns/1ns
module dcpo_top #(
	parameter int NOUT       = 8,
	parameter int FINE_CYC   = dcpo_pkg::TB_FINE_CYC,
	parameter int COARSE_CYC = dcpo_pkg::TB_COARSE_CYC,
	parameter int MICRO_CYC  = dcpo_pkg::TB_MICRO_CYC
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [dcpo_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	output logic      [NOUT-1:0]             pulse_output_connector
);
	dcpo_pkg::dcpo_ctrl_t   ctrl_r;
	logic [NOUT-1:0]        dout_r;
	logic [15:0]            freq_r;
	dcpo_pkg::dcpo_timing_t tim_r [dcpo_pkg::NCH];
	dcpo_pkg::dcpo_sched_t  sched [dcpo_pkg::NCH];
	logic [dcpo_pkg::NCH-1:0] lvl;
	logic [dcpo_pkg::NCH-1:0] supp;
	logic [dcpo_pkg::NCH-1:0] tick;
	logic [15:0]            hf_per;
	logic [31:0]            rd_nxt;
	logic                   err_nxt;
	logic                   hit_ctrl;
	logic                   hit_dout;
	logic                   hit_freq;
	logic                   hit_per;
	logic                   hit_duty;
	logic                   hit_minp;
	logic                   in_ch;
	logic [11:0]            ch_rel;
	logic                   ch_idx;
	logic [3:0]             ch_off;
	logic                   setup;
	logic                   wr_acc;
	logic [15:0]            wv;

	assign setup  = psel && !penable;
	assign wr_acc = psel && penable && pready && pwrite && !pslverr;
	assign wv     = pwdata[15:0];
	assign ch_rel = paddr - dcpo_pkg::A_CH_BASE;
	assign ch_idx = ch_rel[dcpo_pkg::CH_SHIFT];
	assign ch_off = ch_rel[3:0];
	assign in_ch  = (paddr >= dcpo_pkg::A_CH_BASE) && (paddr < dcpo_pkg::A_CH_END);

	// address decode and read data; out-of-range writes are refused, not clipped
	always_comb begin
		rd_nxt   = 32'h0000_0000;
		err_nxt  = 1'b0;
		hit_ctrl = 1'b0;
		hit_dout = 1'b0;
		hit_freq = 1'b0;
		hit_per  = 1'b0;
		hit_duty = 1'b0;
		hit_minp = 1'b0;
		if (paddr[1:0] != 2'b00) begin
			err_nxt = 1'b1;
		end else if (paddr == dcpo_pkg::A_CTRL) begin
			hit_ctrl = 1'b1;
			rd_nxt   = {{(32-dcpo_pkg::CTRL_W){1'b0}}, ctrl_r};
		end else if (paddr == dcpo_pkg::A_DOUT) begin
			hit_dout = 1'b1;
			rd_nxt   = {{(32-NOUT){1'b0}}, dout_r};
		end else if (paddr == dcpo_pkg::A_FREQ) begin
			hit_freq = 1'b1;
			rd_nxt   = {16'h0000, freq_r};
			err_nxt  = pwrite && !dcpo_pkg::in_range(wv, dcpo_pkg::FREQ_MIN,
				dcpo_pkg::FREQ_MAX);
		end else if (paddr == dcpo_pkg::A_STATUS) begin
			rd_nxt  = {{(28-NOUT){1'b0}}, pulse_output_connector, supp, lvl};
			err_nxt = pwrite;
		end else if (in_ch) begin
			if (ch_off == dcpo_pkg::OFF_PERIOD) begin
				hit_per = 1'b1;
				rd_nxt  = {16'h0000, tim_r[ch_idx].period};
				err_nxt = pwrite && !dcpo_pkg::in_range(wv, dcpo_pkg::PERIOD_MIN,
					dcpo_pkg::PERIOD_MAX);
			end else if (ch_off == dcpo_pkg::OFF_DUTY) begin
				hit_duty = 1'b1;
				rd_nxt   = {22'h000000, tim_r[ch_idx].duty};
				err_nxt  = pwrite && !dcpo_pkg::in_range(wv, dcpo_pkg::DUTY_MIN,
					dcpo_pkg::DUTY_MAX);
			end else if (ch_off == dcpo_pkg::OFF_MINP) begin
				hit_minp = 1'b1;
				rd_nxt   = {16'h0000, tim_r[ch_idx].minp};
				err_nxt  = pwrite && !dcpo_pkg::in_range(wv, dcpo_pkg::MINP_STD_MIN,
					dcpo_pkg::MINP_MAX);
			end else begin
				err_nxt = 1'b1;
			end
		end else begin
			err_nxt = 1'b1;
		end
	end

	// answer comes in the first access cycle: no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (setup) begin
			pready  <= 1'b1;
			pslverr <= err_nxt;
			prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= '0;
		end else if (wr_acc && hit_ctrl) begin
			// a single mode bit means the channels can never disagree on the type
			ctrl_r <= dcpo_pkg::dcpo_ctrl_t'(pwdata[dcpo_pkg::CTRL_W-1:0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout_r <= '0;
		end else if (wr_acc && hit_dout) begin
			dout_r <= pwdata[NOUT-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_r <= dcpo_pkg::FREQ_RST;
		end else if (wr_acc && hit_freq) begin
			freq_r <= wv;
		end
	end

	// running channels pick these up at their next period boundary
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < dcpo_pkg::NCH; i++) begin
				tim_r[i].period <= dcpo_pkg::PERIOD_RST;
				tim_r[i].duty   <= dcpo_pkg::DUTY_RST;
				tim_r[i].minp   <= dcpo_pkg::MINP_RST;
			end
		end else if (wr_acc) begin
			if (hit_per) begin
				tim_r[ch_idx].period <= wv;
			end else if (hit_duty) begin
				tim_r[ch_idx].duty <= wv[9:0];
			end else if (hit_minp) begin
				tim_r[ch_idx].minp <= wv;
			end
		end
	end

	assign hf_per = dcpo_pkg::hf_period_ticks(freq_r);

	for (genvar c = 0; c < dcpo_pkg::NCH; c++) begin : g_ch
		dcpo_pkg::dcpo_tb_t tb_sel;
		logic [15:0]        per_t;

		always_comb begin
			if (ctrl_r.high_frequency_modulation_mode) begin
				tb_sel = dcpo_pkg::DCPO_TB_MICRO;
			end else if (ctrl_r.tb_coarse[c]) begin
				tb_sel = dcpo_pkg::DCPO_TB_COARSE;
			end else begin
				tb_sel = dcpo_pkg::DCPO_TB_FINE;
			end
		end

		assign per_t = ctrl_r.high_frequency_modulation_mode ? hf_per : tim_r[c].period;
		assign sched[c].period = per_t;
		// division truncates, so the pulse lands on the lower tick boundary
		assign sched[c].pulse = dcpo_pkg::pulse_ticks(per_t, tim_r[c].duty);
		// microsecond minimum is floored at 2 even if a 1 was kept from standard mode
		assign sched[c].minp = (ctrl_r.high_frequency_modulation_mode &&
			(tim_r[c].minp < dcpo_pkg::MINP_HF_MIN)) ? dcpo_pkg::MINP_HF_MIN :
			tim_r[c].minp;

		dcpo_tick_gen #(
			.FINE_CYC   (FINE_CYC),
			.COARSE_CYC (COARSE_CYC),
			.MICRO_CYC  (MICRO_CYC)
		) u_tick (
			.pclk    (pclk),
			.presetn (presetn),
			.clr     (!ctrl_r.en[c]),
			.sel     (tb_sel),
			.tick    (tick[c])
		);

		dcpo_channel u_chan (
			.pclk       (pclk),
			.presetn    (presetn),
			.en         (ctrl_r.en[c]),
			.tick       (tick[c]),
			.sched      (sched[c]),
			.level      (lvl[c]),
			.suppressed (supp[c])
		);
	end

	// only the two top outputs can carry pulses; the rest always follow dout
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_output_connector <= '0;
		end else begin
			pulse_output_connector[NOUT-3:0] <= dout_r[NOUT-3:0];
			pulse_output_connector[NOUT-2] <= ctrl_r.en[0] ? lvl[0] : dout_r[NOUT-2];
			pulse_output_connector[NOUT-1] <= ctrl_r.en[1] ? lvl[1] : dout_r[NOUT-1];
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_dis_normal: assert property (
		!ctrl_r.en[0] |=> pulse_output_connector[NOUT-2] == $past(dout_r[NOUT-2]))
		else $error("disabled channel 0 does not follow output data");
	a_en_drives: assert property (
		ctrl_r.en[1] |=> pulse_output_connector[NOUT-1] == $past(lvl[1]))
		else $error("enabled channel 1 does not drive the pulse level");
	a_low_plain: assert property (
		##1 pulse_output_connector[NOUT-3:0] == $past(dout_r[NOUT-3:0]))
		else $error("pulse leaked onto a plain output");
	a_stay_off: assert property (
		!(wr_acc && hit_ctrl) && (ctrl_r.en == 2'b00) |=> ctrl_r.en == 2'b00)
		else $error("channel enabled without a control write");
	a_period_legal: assert property (
		dcpo_pkg::in_range(tim_r[0].period, dcpo_pkg::PERIOD_MIN, dcpo_pkg::PERIOD_MAX)
		&& dcpo_pkg::in_range(tim_r[1].period, dcpo_pkg::PERIOD_MIN, dcpo_pkg::PERIOD_MAX))
		else $error("period count outside its range");
	a_duty_legal: assert property (
		dcpo_pkg::in_range({6'h00, tim_r[0].duty}, dcpo_pkg::DUTY_MIN, dcpo_pkg::DUTY_MAX))
		else $error("duty outside its range");
	a_freq_legal: assert property (
		dcpo_pkg::in_range(freq_r, dcpo_pkg::FREQ_MIN, dcpo_pkg::FREQ_MAX))
		else $error("frequency outside its range");
	a_trunc_down: assert property (
		({10'h000, sched[0].pulse} * dcpo_pkg::PERMIL <=
			{10'h000, sched[0].period} * {16'h0000, tim_r[0].duty}) &&
		(({10'h000, sched[0].pulse} + 26'h0000001) * dcpo_pkg::PERMIL >
			{10'h000, sched[0].period} * {16'h0000, tim_r[0].duty}))
		else $error("pulse not truncated to the lower tick");
	a_hf_minp: assert property (
		ctrl_r.high_frequency_modulation_mode |-> sched[1].minp >= dcpo_pkg::MINP_HF_MIN)
		else $error("microsecond minimum pulse below 2");
	a_bad_refused: assert property (
		setup && pwrite && hit_per && !ch_idx &&
		!dcpo_pkg::in_range(wv, dcpo_pkg::PERIOD_MIN, dcpo_pkg::PERIOD_MAX)
		##1 (psel && penable) |-> pslverr ##1 $stable(tim_r[0].period))
		else $error("illegal period write was taken");
	a_hf_shared: assert property (
		ctrl_r.high_frequency_modulation_mode |-> sched[0].period == sched[1].period)
		else $error("channels disagree on the shared period");
	a_dis_normal1: assert property (
		!ctrl_r.en[1] |=> pulse_output_connector[NOUT-1] == $past(dout_r[NOUT-1]))
		else $error("disabled channel 1 does not follow output data");
	a_en_drives0: assert property (
		ctrl_r.en[0] |=> pulse_output_connector[NOUT-2] == $past(lvl[0]))
		else $error("enabled channel 0 does not drive the pulse level");
	a_off_quiet: assert property (
		(lvl & ~ctrl_r.en) == 2'b00)
		else $error("disabled channel shows a pulse level");
	a_spike_low: assert property (
		(lvl & supp) == 2'b00)
		else $error("suppressed pulse reached the output");
	a_duty_legal1: assert property (
		dcpo_pkg::in_range({6'h00, tim_r[1].duty}, dcpo_pkg::DUTY_MIN, dcpo_pkg::DUTY_MAX))
		else $error("channel 1 duty outside its range");
	a_minp_legal: assert property (
		dcpo_pkg::in_range(tim_r[0].minp, dcpo_pkg::MINP_STD_MIN, dcpo_pkg::MINP_MAX)
		&& dcpo_pkg::in_range(tim_r[1].minp, dcpo_pkg::MINP_STD_MIN, dcpo_pkg::MINP_MAX))
		else $error("minimum pulse outside its range");
	a_trunc_down1: assert property (
		({10'h000, sched[1].pulse} * dcpo_pkg::PERMIL <=
			{10'h000, sched[1].period} * {16'h0000, tim_r[1].duty}) &&
		(({10'h000, sched[1].pulse} + 26'h0000001) * dcpo_pkg::PERMIL >
			{10'h000, sched[1].period} * {16'h0000, tim_r[1].duty}))
		else $error("channel 1 pulse not truncated to the lower tick");
	a_hf_minp0: assert property (
		ctrl_r.high_frequency_modulation_mode |-> sched[0].minp >= dcpo_pkg::MINP_HF_MIN)
		else $error("channel 0 microsecond minimum pulse below 2");
	a_minp_keep: assert property (
		tim_r[0].minp >= dcpo_pkg::MINP_HF_MIN |-> sched[0].minp == tim_r[0].minp)
		else $error("legal minimum pulse was altered");
	a_std_period: assert property (
		!ctrl_r.high_frequency_modulation_mode |->
		sched[0].period == tim_r[0].period && sched[1].period == tim_r[1].period)
		else $error("standard period does not follow the period count");
	a_hf_period: assert property (
		ctrl_r.high_frequency_modulation_mode |->
		({16'h0000, sched[0].period} * {16'h0000, freq_r} <=
			{12'h000, dcpo_pkg::US_PER_S}) &&
		(({16'h0000, sched[0].period} + 32'h0000_0001) * {16'h0000, freq_r} >
			{12'h000, dcpo_pkg::US_PER_S}))
		else $error("high-frequency period is not one over the frequency");
	a_ready_setup: assert property (
		setup |=> pready)
		else $error("no answer in the first access cycle");
	a_ready_pulse: assert property (
		pready |=> !pready)
		else $error("answer stood longer than one cycle");
	a_err_ready: assert property (
		pslverr |-> pready)
		else $error("error flag outside an answer");
	a_idle_rdata: assert property (
		!pready |-> prdata == 32'h0000_0000)
		else $error("read data shown outside an answer");
	a_bad_duty: assert property (
		setup && pwrite && hit_duty && !ch_idx &&
		!dcpo_pkg::in_range(wv, dcpo_pkg::DUTY_MIN, dcpo_pkg::DUTY_MAX)
		##1 (psel && penable) |-> pslverr ##1 $stable(tim_r[0].duty))
		else $error("illegal duty write was taken");
	a_bad_minp: assert property (
		setup && pwrite && hit_minp && !ch_idx &&
		!dcpo_pkg::in_range(wv, dcpo_pkg::MINP_STD_MIN, dcpo_pkg::MINP_MAX)
		##1 (psel && penable) |-> pslverr ##1 $stable(tim_r[0].minp))
		else $error("illegal minimum pulse write was taken");
	a_bad_freq: assert property (
		setup && pwrite && hit_freq &&
		!dcpo_pkg::in_range(wv, dcpo_pkg::FREQ_MIN, dcpo_pkg::FREQ_MAX)
		##1 (psel && penable) |-> pslverr ##1 $stable(freq_r))
		else $error("illegal frequency write was taken");
	a_ctrl_write: assert property (
		wr_acc && hit_ctrl |=> ctrl_r == $past(pwdata[dcpo_pkg::CTRL_W-1:0]))
		else $error("control write did not land");
	a_dout_write: assert property (
		wr_acc && hit_dout |=> dout_r == $past(pwdata[NOUT-1:0]))
		else $error("output data write did not land");
	a_live_write: assert property (
		wr_acc && hit_duty && !ch_idx |=> tim_r[0].duty == $past(wv[9:0]))
		else $error("duty write while running did not land");
endmodule // dcpo_top

// *** verif/dcpo_drive_model.sv ***
`timescale 1ns/1ns
// power-stage side: only watches the pulse pin, measures widths in clock cycles
module dcpo_drive_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin,
	output int        high_cyc,
	output int        per_cyc,
	output int        rises,
	output int        falls
);
	logic prev;
	int   hc;
	int   pc;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev     <= 1'b0;
			hc       <= 0;
			pc       <= 0;
			high_cyc <= 0;
			per_cyc  <= 0;
			rises    <= 0;
			falls    <= 0;
		end else begin
			prev <= pin;
			hc   <= pin ? hc + 1 : 0;
			pc   <= pc + 1;
			// period measured rise to rise, so a fresh enable needs two rises first
			if (pin && !prev) begin
				rises   <= rises + 1;
				per_cyc <= pc;
				pc      <= 1;
			end
			if (!pin && prev) begin
				falls    <= falls + 1;
				high_cyc <= hc;
			end
		end
	end
endmodule // dcpo_drive_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	localparam int FC = 20;
	localparam int CC = 40;
	localparam int MC = 10;
	typedef struct {
		int ch; int hf; int crs; int p; int d; int m; int f;
	} dcpo_row_t;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  pins;
	logic [31:0] rdat;
	logic        rerr;
	int          hi0, pe0, rs0, fl0, hi1, pe1, rs1, fl1;
	int          failures;
	int          checks;
	dcpo_row_t   rows[7];

	dcpo_top #(.NOUT(8), .FINE_CYC(FC), .COARSE_CYC(CC), .MICRO_CYC(MC)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pulse_output_connector(pins));
	dcpo_drive_model m0 (.pclk(pclk), .presetn(presetn), .pin(pins[6]),
		.high_cyc(hi0), .per_cyc(pe0), .rises(rs0), .falls(fl0));
	dcpo_drive_model m1 (.pclk(pclk), .presetn(presetn), .pin(pins[7]),
		.high_cyc(hi1), .per_cyc(pe1), .rises(rs1), .falls(fl1));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic stop_test();
		if (failures == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			stop_test();
		end
		rdat    = prdata;
		rerr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic int cnt(input int ch, input bit rise);
		return rise ? (ch ? rs1 : rs0) : (ch ? fl1 : fl0);
	endfunction

	// waits for the next rising or falling edge on a channel pin, bounded
	task automatic wait_ev(input int ch, input bit rise);
		int n;
		int s;
		s = cnt(ch, rise);
		n = 0;
		while (cnt(ch, rise) == s && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20000) begin
			failures++;
			stop_test();
		end
	endtask

	task automatic run_row(input dcpo_row_t r);
		logic [11:0] b;
		int tc, pt, mt, ht, s;
		b = dcpo_pkg::A_CH_BASE + (12'(r.ch) << dcpo_pkg::CH_SHIFT);
		tc = r.hf ? MC : (r.crs ? CC : FC);
		pt = r.hf ? 1000000 / r.f : r.p;
		mt = (r.hf && r.m < 2) ? 2 : r.m;
		ht = pt * r.d / 1000;
		apb(1'b1, dcpo_pkg::A_CTRL, 32'h0);
		apb(1'b1, b + 12'(dcpo_pkg::OFF_PERIOD), 32'(r.p));
		apb(1'b1, b + 12'(dcpo_pkg::OFF_DUTY), 32'(r.d));
		apb(1'b1, b + 12'(dcpo_pkg::OFF_MINP), 32'(r.m));
		apb(1'b1, dcpo_pkg::A_FREQ, 32'(r.f));
		apb(1'b1, dcpo_pkg::A_CTRL, 32'((1 << r.ch) | (r.hf << 2) | (r.crs << (3 + r.ch))));
		if (ht <= mt) begin
			s = cnt(r.ch, 1'b1);
			repeat (3 * pt * tc) @(posedge pclk);
			`CHK("no pulse", s, cnt(r.ch, 1'b1))
			apb(1'b0, dcpo_pkg::A_STATUS, 32'h0);
			`CHK("suppressed", 1'b1, rdat[2 + r.ch])
		end else begin
			repeat (3) wait_ev(r.ch, 1'b1);
			`CHK("period", pt * tc, r.ch ? pe1 : pe0)
			`CHK("high", ht * tc, r.ch ? hi1 : hi0)
		end
	endtask

	initial begin
		failures = 0;
		checks   = 0;
		presetn  = 1'b0;
		psel     = 1'b0;
		penable  = 1'b0;
		pwrite   = 1'b0;
		paddr    = 12'h000;
		pwdata   = 32'h0;
		// settings keep pulse and break above the minimum except the filter cases
		rows[0] = '{0, 0, 0, 10, 300, 1, 2500};
		rows[1] = '{0, 0, 0, 10, 250, 1, 2500};
		rows[2] = '{1, 0, 1, 5, 400, 1, 2500};
		rows[3] = '{0, 1, 0, 2, 500, 2, 50000};
		rows[4] = '{1, 1, 0, 2, 10, 2, 2500};
		rows[5] = '{0, 0, 0, 10, 300, 3, 2500};
		rows[6] = '{1, 1, 0, 2, 100, 1, 50000};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, dcpo_pkg::A_CTRL, 32'h0);
		`CHK("ctrl rst", 32'h0, rdat)
		`CHK("pins rst", 8'h00, pins)
		apb(1'b0, dcpo_pkg::A_CH_BASE, 32'h0);
		`CHK("period rst", 32'(dcpo_pkg::PERIOD_RST), rdat)
		foreach (rows[i]) run_row(rows[i]);
		// refused accesses leave state alone
		apb(1'b1, dcpo_pkg::A_CH_BASE, 32'h1);
		`CHK("bad period err", 1'b1, rerr)
		apb(1'b1, dcpo_pkg::A_CH_BASE + 12'(dcpo_pkg::OFF_DUTY), 32'h3e9);
		`CHK("bad duty err", 1'b1, rerr)
		apb(1'b1, dcpo_pkg::A_CH_BASE + 12'(dcpo_pkg::OFF_MINP), 32'h0);
		`CHK("bad minp err", 1'b1, rerr)
		apb(1'b1, dcpo_pkg::A_FREQ, 32'h9c3);
		`CHK("bad freq err", 1'b1, rerr)
		apb(1'b0, dcpo_pkg::A_CH_BASE, 32'h0);
		`CHK("period kept", 32'ha, rdat)
		apb(1'b0, 12'h100, 32'h0);
		`CHK("unmapped err", 1'b1, rerr)
		apb(1'b1, dcpo_pkg::A_STATUS, 32'h0);
		`CHK("ro err", 1'b1, rerr)
		// duty rewritten mid-pulse: running period keeps old width
		run_row(rows[0]);
		wait_ev(0, 1'b1);
		apb(1'b1, dcpo_pkg::A_CH_BASE + 12'(dcpo_pkg::OFF_DUTY), 32'd500);
		`CHK("live write ok", 1'b0, rerr)
		wait_ev(0, 1'b0);
		`CHK("old high", 3 * FC, hi0)
		wait_ev(0, 1'b0);
		`CHK("new high", 5 * FC, hi0)
		// plain data on the other outputs while channel 0 pulses
		apb(1'b1, dcpo_pkg::A_DOUT, 32'hbf);
		repeat (3) @(posedge pclk);
		`CHK("low pins", 6'h3f, pins[5:0])
		`CHK("ch1 off pin", 1'b1, pins[7])
		apb(1'b1, dcpo_pkg::A_CTRL, 32'h0);
		repeat (3) @(posedge pclk);
		`CHK("ch0 off pin", 1'b0, pins[6])
		apb(1'b1, dcpo_pkg::A_DOUT, 32'h40);
		repeat (3) @(posedge pclk);
		`CHK("ch0 dout", 8'h40, pins)
		// reset in mid-run while channel 1 pulses
		run_row(rows[2]);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK("pins mid rst", 8'h00, pins)
		presetn <= 1'b1;
		apb(1'b0, dcpo_pkg::A_CTRL, 32'h0);
		`CHK("ctrl mid rst", 32'h0, rdat)
		repeat (600) @(posedge pclk);
		`CHK("pins idle", 8'h00, pins)
		stop_test();
	end
endmodule // tb_top
